// [rtl/hdm_top.sv]
/*
 Harmonic distortion alarm monitor with AXI4-Lite register access.
 Assumes distortion figures arrive ready-made and time_ms is the relay's millisecond clock.

*/
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module hdm_top import hdm_pkg::*; #(
	parameter int unsigned CYCLE_CLKS = HDM_PROC_CYCLE_CLKS,
	parameter int unsigned LOG_DEPTH = HDM_LOG_DEPTH
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Measurements: L1, L2, L3, residual one, residual two
	input wire logic [HDM_NMEAS-1:0][HDM_VAL_W-1:0] meas_amp,
	input wire logic [HDM_NMEAS-1:0][HDM_VAL_W-1:0] meas_pow,
	input wire logic blocking_in,
	input wire logic [HDM_TS_W-1:0] time_ms,
	input wire logic [2:0] setting_group,
	// Indications
	output logic [HDM_NCHAN-1:0] chan_start,
	output logic [HDM_NCHAN-1:0] chan_alarm,
	output logic chan_blocked,
	output logic [1:0] monitor_state,
	// Events
	output logic [HDM_NSRC-1:0] evt_on,
	output logic [HDM_NSRC-1:0] evt_off,
	output logic [HDM_TS_W-1:0] evt_time
);
	localparam int unsigned DIV_W = $clog2(CYCLE_CLKS);
	localparam int unsigned LAW = $clog2(LOG_DEPTH);

	if (CYCLE_CLKS < 4 || LOG_DEPTH < 2 || LOG_DEPTH > 15) begin : g_chk
		$error("hdm_top: unsupported cycle length or log depth");
	end

	function automatic logic [31:0] hdm_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] m;
		for (int b = 0; b < 4; b++) begin
			m[8*b +: 8] = {8{strb[b]}};
		end
		return (old & ~m) | (nw & m);
	endfunction

	function automatic logic hdm_addr_ok(input logic [7:0] a);
		return a[1:0] == 2'h0 && a <= HDM_OFF_LAST;
	endfunction

	logic [DIV_W-1:0] div_r;
	logic tick_r, eval_r, block_smp_r;
	logic [HDM_NMEAS-1:0][HDM_VAL_W-1:0] meas_r, meas_sel_w;
	logic [HDM_NCHAN-1:0][HDM_VAL_W-1:0] chan_val_w, pickup_r;
	logic [HDM_NCHAN-1:0][HDM_DELAY_W-1:0] delay_r;
	logic [HDM_NCHAN-1:0][31:0] pk_wd_w, dl_wd_w;
	logic [HDM_VAL_W-1:0] ph_max_w;
	logic [2:0] en_r;
	logic mag_r;
	logic [HDM_NSRC-1:0] chan_blk_w, src_w, src_prev_r, on_w, off_w, on_mask_r, off_mask_r;
	logic [HDM_NCHAN-1:0] chan_blk_vec_w;
	hdm_mon_e mon_r, mon_w;
	logic [2:0][31:0] cnt_r;
	logic [2:0][1:0] inc_w;
	logic [3:0] code_w, log_idx_r, log_cnt_r;
	logic [LAW-1:0] log_wp_r;
	logic [3:0][31:0] log_word_w;
	logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r, w_data_r, rd_w;
	logic [7:0] aw_addr_r;
	logic [3:0] w_strb_r;

	hdm_log_if #(.W(HDM_LOG_W), .DEPTH(LOG_DEPTH)) lif();

	hdm_log_mem #(.W(HDM_LOG_W), .DEPTH(LOG_DEPTH)) u_log (
		.aclk(aclk),
		.aresetn(aresetn),
		.lif(lif.mem)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Processing cycle divider and input sampling
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_r <= '0;
			tick_r <= 1'b0;
		end else begin
			tick_r <= div_r == DIV_W'(CYCLE_CLKS - 1);
			div_r <= (div_r == DIV_W'(CYCLE_CLKS - 1)) ? '0 : DIV_W'(div_r + 1'b1);
		end
	end

	for (genvar i = 0; i < HDM_NMEAS; i++) begin : g_sel
		assign meas_sel_w[i] = mag_r ? meas_pow[i] : meas_amp[i];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			eval_r <= 1'b0;
			block_smp_r <= 1'b0;
			meas_r <= '0;
		end else begin
			eval_r <= tick_r;
			if (tick_r) begin
				block_smp_r <= blocking_in;
				meas_r <= meas_sel_w;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Alarm channels
	assign ph_max_w = (meas_r[0] > meas_r[1]) ? meas_r[0] : meas_r[1];
	assign chan_val_w[0] = (ph_max_w > meas_r[2]) ? ph_max_w : meas_r[2];
	assign chan_val_w[1] = meas_r[3];
	assign chan_val_w[2] = meas_r[4];

	for (genvar c = 0; c < HDM_NCHAN; c++) begin : g_chan
		hdm_chan u_chan (
			.aclk(aclk),
			.aresetn(aresetn),
			.eval(eval_r),
			.enable(en_r[c]),
			.blocking(block_smp_r),
			.value(chan_val_w[c]),
			.setting(pickup_r[c]),
			.delay(delay_r[c]),
			.start(chan_start[c]),
			.alarm(chan_alarm[c]),
			.blocked(chan_blk_vec_w[c])
		);
	end

	assign chan_blk_w = {|chan_blk_vec_w, 6'h00};
	assign src_w = {chan_blk_w[HDM_SRC_BLK], chan_alarm, chan_start};
	assign on_w = src_w & ~src_prev_r;
	assign off_w = ~src_w & src_prev_r;
	assign mon_w = src_w[HDM_SRC_BLK] ? HDM_BLOCKED : (|chan_alarm) ? HDM_ALARM :
		(|chan_start) ? HDM_START : HDM_NORMAL;

	////////////////////////////////////////////////////////////////////////////////
	// Events, status and counters
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src_prev_r <= '0;
			evt_on <= '0;
			evt_off <= '0;
			evt_time <= '0;
			mon_r <= HDM_NORMAL;
		end else begin
			src_prev_r <= src_w;
			evt_on <= on_w & on_mask_r;
			evt_off <= off_w & off_mask_r;
			if (|(on_w | off_w)) begin
				evt_time <= time_ms;
			end
			mon_r <= mon_w;
		end
	end

	assign chan_blocked = src_prev_r[HDM_SRC_BLK];
	assign monitor_state = mon_r;
	assign inc_w[0] = 2'($countones(on_w[2:0]));
	assign inc_w[1] = 2'($countones(on_w[5:3]));
	assign inc_w[2] = {1'b0, on_w[HDM_SRC_BLK]};

	wire logic [31:0] ctrl_wd_w = hdm_merge({27'h0, 1'b0, mag_r, en_r}, w_data_r, w_strb_r);
	wire logic [31:0] mask_wd_w = hdm_merge({17'h0, off_mask_r, 1'b0, on_mask_r}, w_data_r, w_strb_r);
	wire logic [31:0] lctl_wd_w = hdm_merge({28'h0, log_idx_r}, w_data_r, w_strb_r);
	wire logic do_write = !awready_r && !wready_r && !bvalid_r;
	wire logic wr_ok = hdm_addr_ok(aw_addr_r);
	wire logic wr_we = do_write && wr_ok;
	wire logic cnt_clr_w = wr_we && aw_addr_r == HDM_OFF_CTRL && ctrl_wd_w[HDM_CTRL_CLR_BIT];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= '0;
		end else begin
			for (int k = 0; k < 3; k++) begin
				// A clear in the same cycle as an event keeps that event
				cnt_r[k] <= cnt_clr_w ? 32'(inc_w[k]) : cnt_r[k] + 32'(inc_w[k]);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Event log, written on ON transitions only
	always_comb begin
		code_w = 4'h0;
		for (int s = 0; s < HDM_NSRC; s++) begin
			if (on_w[s]) begin
				code_w = 4'(s);
			end
		end
	end

	assign lif.we = |on_w;
	assign lif.waddr = log_wp_r;
	assign lif.wdata = {16'h0000, meas_r[2], meas_r[1], meas_r[0], 9'h000, setting_group, code_w, time_ms};
	assign lif.raddr = LAW'(log_idx_r);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			log_wp_r <= '0;
			log_cnt_r <= 4'h0;
		end else if (lif.we) begin
			log_wp_r <= (log_wp_r == LAW'(LOG_DEPTH - 1)) ? '0 : LAW'(log_wp_r + 1'b1);
			if (log_cnt_r != 4'(LOG_DEPTH)) begin
				log_cnt_r <= 4'(log_cnt_r + 1'b1);
			end
		end
	end

	for (genvar k = 0; k < 4; k++) begin : g_lw
		assign log_word_w[k] = (log_idx_r < log_cnt_r) ? lif.rdata[32*k +: 32] : 32'h0000_0000;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register writes
	for (genvar c = 0; c < HDM_NCHAN; c++) begin : g_wd
		assign pk_wd_w[c] = hdm_merge({16'h0000, pickup_r[c]}, w_data_r, w_strb_r);
		assign dl_wd_w[c] = hdm_merge({13'h0000, delay_r[c]}, w_data_r, w_strb_r);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en_r <= HDM_EN_DEF;
			mag_r <= 1'b0;
			pickup_r <= {HDM_NCHAN{HDM_PICKUP_DEF}};
			delay_r <= {HDM_NCHAN{HDM_DELAY_DEF}};
			on_mask_r <= HDM_MASK_DEF;
			off_mask_r <= HDM_MASK_DEF;
			log_idx_r <= 4'h0;
		end else if (wr_we) begin
			if (aw_addr_r == HDM_OFF_CTRL) begin
				en_r <= ctrl_wd_w[2:0];
				mag_r <= ctrl_wd_w[HDM_CTRL_MAG_BIT];
			end
			if (aw_addr_r == HDM_OFF_EVT_MASK) begin
				on_mask_r <= mask_wd_w[HDM_NSRC-1:0];
				off_mask_r <= mask_wd_w[HDM_EVT_OFF_LSB +: HDM_NSRC];
			end
			if (aw_addr_r == HDM_OFF_LOG_CTRL && lctl_wd_w[3:0] < 4'(LOG_DEPTH)) begin
				log_idx_r <= lctl_wd_w[3:0];
			end
			for (int c = 0; c < HDM_NCHAN; c++) begin
				if (aw_addr_r == 8'(HDM_OFF_PICKUP0 + HDM_REG_STRIDE * c)) begin
					pickup_r[c] <= pk_wd_w[c][HDM_VAL_W-1:0];
				end
				if (aw_addr_r == 8'(HDM_OFF_DELAY0 + HDM_REG_STRIDE * c)) begin
					// Settings whose low 19 bits pass the longest delay are held at it; higher bits are dropped
					delay_r[c] <= (dl_wd_w[c][HDM_DELAY_W-1:0] > HDM_DELAY_MAX) ? HDM_DELAY_MAX :
						dl_wd_w[c][HDM_DELAY_W-1:0];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register reads
	always_comb begin
		rd_w = 32'h0000_0000;
		if (s_axi_araddr == HDM_OFF_CTRL) rd_w = {28'h0, mag_r, en_r};
		if (s_axi_araddr == HDM_OFF_STATUS) rd_w = {23'h0, src_prev_r, mon_r};
		if (s_axi_araddr == HDM_OFF_EVT_MASK) rd_w = {17'h0, off_mask_r, 1'b0, on_mask_r};
		if (s_axi_araddr == HDM_OFF_LOG_CTRL) rd_w = {20'h0, 4'(log_wp_r), log_cnt_r, log_idx_r};
		for (int c = 0; c < HDM_NCHAN; c++) begin
			if (s_axi_araddr == 8'(HDM_OFF_PICKUP0 + HDM_REG_STRIDE * c)) rd_w = {16'h0, pickup_r[c]};
			if (s_axi_araddr == 8'(HDM_OFF_DELAY0 + HDM_REG_STRIDE * c)) rd_w = {13'h0, delay_r[c]};
			if (s_axi_araddr == 8'(HDM_OFF_CNT0 + HDM_REG_STRIDE * c)) rd_w = cnt_r[c];
		end
		for (int k = 0; k < 4; k++) begin
			if (s_axi_araddr == 8'(HDM_OFF_LOG_W0 + HDM_REG_STRIDE * k)) rd_w = log_word_w[k];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite handshakes
	wire logic aw_take = s_axi_awvalid && awready_r;
	wire logic w_take = s_axi_wvalid && wready_r;
	wire logic b_done = bvalid_r && s_axi_bready;
	wire logic ar_take = s_axi_arvalid && arready_r;
	wire logic r_done = rvalid_r && s_axi_rready;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			bvalid_r <= 1'b0;
			bresp_r <= HDM_RESP_OKAY;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
		end else begin
			if (aw_take) begin
				awready_r <= 1'b0;
				aw_addr_r <= s_axi_awaddr;
			end else if (b_done) begin
				awready_r <= 1'b1;
			end
			if (w_take) begin
				wready_r <= 1'b0;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end else if (b_done) begin
				wready_r <= 1'b1;
			end
			if (do_write) begin
				bvalid_r <= 1'b1;
				bresp_r <= wr_ok ? HDM_RESP_OKAY : HDM_RESP_SLVERR;
			end else if (b_done) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rresp_r <= HDM_RESP_OKAY;
			rdata_r <= 32'h0000_0000;
		end else if (ar_take) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rresp_r <= hdm_addr_ok(s_axi_araddr) ? HDM_RESP_OKAY : HDM_RESP_SLVERR;
			rdata_r <= hdm_addr_ok(s_axi_araddr) ? rd_w : 32'h0000_0000;
		end else if (r_done) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_tick_eval;
		tick_r ##1 eval_r;
	endsequence

	sequence s_blk_on;
		$rose(src_w[HDM_SRC_BLK]) && on_mask_r[HDM_SRC_BLK];
	endsequence

	block_sample_a: assert property (s_tick_eval |-> block_smp_r == $past(blocking_in))
		else $error("blocking not sampled at cycle start");
	status_prio_a: assert property (chan_blocked |-> monitor_state == HDM_BLOCKED)
		else $error("blocked not reported first");
	status_alarm_a: assert property (!chan_blocked && $past(|chan_alarm) |-> monitor_state == HDM_ALARM)
		else $error("alarm not reported");
	blk_event_a: assert property (s_blk_on |=> evt_on[HDM_SRC_BLK] ##1 !evt_on[HDM_SRC_BLK])
		else $error("blocked ON event missing or held");
	blk_count_a: assert property (on_w[HDM_SRC_BLK] && !cnt_clr_w |=> cnt_r[2] == $past(cnt_r[2]) + 32'h1)
		else $error("blocked counter not advanced");
	log_wrap_a: assert property (lif.we |=> log_wp_r == (($past(log_wp_r) == LAW'(LOG_DEPTH - 1)) ? '0 :
		LAW'($past(log_wp_r) + 1'b1)))
		else $error("log pointer wrong");
	bad_read_a: assert property (ar_take && !hdm_addr_ok(s_axi_araddr) |=> s_axi_rvalid
		&& s_axi_rresp == HDM_RESP_SLVERR)
		else $error("unmapped read not refused");
endmodule

// [inc/hdm_pkg.sv]
/*
 Shared constants, register map and types of the harmonic distortion alarm monitor.
 Assumes a 250 MHz clock and a 5 ms processing cycle derived from it.
*/
package hdm_pkg;
	// Timing
	localparam int unsigned HDM_CLK_PERIOD_NS = 4;
	localparam int unsigned HDM_PROC_CYCLE_MS = 5;
	localparam int unsigned HDM_PROC_CYCLE_CLKS = HDM_PROC_CYCLE_MS * 1000000 / HDM_CLK_PERIOD_NS;
	localparam int unsigned HDM_DELAY_DEF_MS = 10000;
	localparam int unsigned HDM_DELAY_MAX_MS = 1800000;
	localparam int unsigned HDM_DELAY_W = 19;
	localparam logic [18:0] HDM_DELAY_DEF = 19'(HDM_DELAY_DEF_MS / HDM_PROC_CYCLE_MS);
	localparam logic [18:0] HDM_DELAY_MAX = 19'(HDM_DELAY_MAX_MS / HDM_PROC_CYCLE_MS);
	// Sizes
	localparam int unsigned HDM_VAL_W = 16;
	localparam int unsigned HDM_TS_W = 48;
	localparam int unsigned HDM_NCHAN = 3;
	localparam int unsigned HDM_NMEAS = 5;
	localparam int unsigned HDM_NSRC = 7;
	localparam int unsigned HDM_LOG_DEPTH = 12;
	localparam int unsigned HDM_LOG_W = 128;
	// Levels in 0.01 % units; dropout ratio in percent
	localparam logic [15:0] HDM_PICKUP_DEF = 16'h03e8;
	localparam logic [6:0] HDM_RESET_RATIO = 7'h61;
	localparam logic [6:0] HDM_PCT_FULL = 7'h64;
	// Register byte offsets
	localparam logic [7:0] HDM_OFF_CTRL = 8'h00;
	localparam logic [7:0] HDM_OFF_STATUS = 8'h04;
	localparam logic [7:0] HDM_OFF_PICKUP0 = 8'h08;
	localparam logic [7:0] HDM_OFF_DELAY0 = 8'h14;
	localparam logic [7:0] HDM_OFF_EVT_MASK = 8'h20;
	localparam logic [7:0] HDM_OFF_CNT0 = 8'h24;
	localparam logic [7:0] HDM_OFF_LOG_CTRL = 8'h30;
	localparam logic [7:0] HDM_OFF_LOG_W0 = 8'h34;
	localparam logic [7:0] HDM_OFF_LAST = 8'h40;
	localparam logic [7:0] HDM_REG_STRIDE = 8'h04;
	// Fields and reset values
	localparam int unsigned HDM_CTRL_MAG_BIT = 3;
	localparam int unsigned HDM_CTRL_CLR_BIT = 4;
	localparam int unsigned HDM_EVT_OFF_LSB = 8;
	localparam logic [2:0] HDM_EN_DEF = 3'h7;
	localparam logic [6:0] HDM_MASK_DEF = 7'h7f;
	localparam int unsigned HDM_SRC_BLK = 6;
	// Bus responses
	localparam logic [1:0] HDM_RESP_OKAY = 2'h0;
	localparam logic [1:0] HDM_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		HDM_NORMAL = 2'h0,
		HDM_START = 2'h1,
		HDM_ALARM = 2'h2,
		HDM_BLOCKED = 2'h3
	} hdm_mon_e;

	typedef enum logic [2:0] {
		HDM_ST_IDLE = 3'h1,
		HDM_ST_RUN = 3'h2,
		HDM_ST_ALARM = 3'h4
	} hdm_chan_e;
endpackage

// [inc/hdm_log_if.sv]
/*
 Port bundle between the monitor core and its event log memory.
 Assumes one writer and one synchronous reader on the same clock.
*/
`timescale 1ns/100ps
interface hdm_log_if #(
	parameter int unsigned W = 128,
	parameter int unsigned DEPTH = 12
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic we;
	logic [AW-1:0] waddr;
	logic [W-1:0] wdata;
	logic [AW-1:0] raddr;
	logic [W-1:0] rdata;
	modport writer(output we, waddr, wdata, raddr, input rdata);
	modport mem(input we, waddr, wdata, raddr, output rdata);
endinterface

// [rtl/hdm_log_mem.sv]
/*
 Event log storage: DEPTH words, one write port, registered read data.
 Assumes the reader keeps raddr below DEPTH.
*/
`timescale 1ns/100ps
module hdm_log_mem #(
	parameter int unsigned W = 128,
	parameter int unsigned DEPTH = 12
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Access bundle
	hdm_log_if.mem lif
);
	logic [W-1:0] store_r [DEPTH];
	logic [W-1:0] rdata_r;

	if (DEPTH < 2 || W < 1) begin : g_chk
		$error("hdm_log_mem: unsupported size");
	end

	always_ff @(posedge aclk) begin
		if (lif.we) begin
			store_r[lif.waddr] <= lif.wdata;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= store_r[lif.raddr];
		end
	end

	assign lif.rdata = rdata_r;
endmodule

// [rtl/hdm_chan.sv]
/*
 One alarm channel: pick-up with dropout hysteresis, blocking and definite-time alarm delay.
 Assumes eval pulses once per processing cycle with value and blocking already sampled.
*/
`timescale 1ns/100ps
module hdm_chan import hdm_pkg::*; #(
	parameter int unsigned VAL_W = HDM_VAL_W,
	parameter int unsigned DLY_W = HDM_DELAY_W
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Processing cycle inputs
	input wire logic eval,
	input wire logic enable,
	input wire logic blocking,
	input wire logic [VAL_W-1:0] value,
	input wire logic [VAL_W-1:0] setting,
	input wire logic [DLY_W-1:0] delay,
	// Indications
	output logic start,
	output logic alarm,
	output logic blocked
);
	hdm_chan_e state_r, state_nxt;
	logic pick_r;
	logic blocked_nxt;
	logic [DLY_W-1:0] cnt_r, cnt_nxt;
	wire logic [VAL_W+6:0] val_scaled = (VAL_W+7)'(value) * (VAL_W+7)'(HDM_PCT_FULL);
	wire logic [VAL_W+6:0] set_scaled = (VAL_W+7)'(setting) * (VAL_W+7)'(HDM_RESET_RATIO);
	wire logic over = value > setting;
	wire logic drop = val_scaled < set_scaled;
	wire logic pick_nxt = enable && (pick_r ? !drop : over);

	if (VAL_W < 8 || DLY_W < 2) begin : g_chk
		$error("hdm_chan: unsupported widths");
	end

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		blocked_nxt = blocked;
		if (eval) begin
			if (!pick_nxt) begin
				// Dropout or disabled channel: full release
				state_nxt = HDM_ST_IDLE;
				cnt_nxt = '0;
				blocked_nxt = 1'b0;
			end else if (blocking || blocked) begin
				// Blocked pick-up is not processed further until it drops out
				state_nxt = HDM_ST_IDLE;
				cnt_nxt = '0;
				blocked_nxt = 1'b1;
			end else begin
				case (state_r)
					HDM_ST_IDLE: begin
						state_nxt = HDM_ST_RUN;
						cnt_nxt = '0;
					end
					HDM_ST_RUN: begin
						cnt_nxt = DLY_W'(cnt_r + 1'b1);
						if (cnt_nxt >= delay) begin
							state_nxt = HDM_ST_ALARM;
						end
					end
					HDM_ST_ALARM: begin
						state_nxt = HDM_ST_ALARM;
					end
					default: begin
						state_nxt = HDM_ST_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= HDM_ST_IDLE;
			cnt_r <= '0;
			pick_r <= 1'b0;
			start <= 1'b0;
			alarm <= 1'b0;
			blocked <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			if (eval) begin
				pick_r <= pick_nxt;
			end
			start <= state_nxt != HDM_ST_IDLE;
			alarm <= state_nxt == HDM_ST_ALARM;
			blocked <= blocked_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	start_cause_a: assert property ($rose(start) |-> $past(eval && !blocking && pick_nxt))
		else $error("start rose without an unblocked pick-up");
	block_stop_a: assert property (eval && blocking && pick_nxt |=> blocked && !start && !alarm)
		else $error("blocked pick-up still processed");
	start_reset_a: assert property (start && eval && blocking |=> !start)
		else $error("start not released by blocking");
	alarm_cause_a: assert property ($rose(alarm) |-> start && $past(state_r) == HDM_ST_RUN
		&& $past(cnt_nxt) >= $past(delay))
		else $error("alarm before delay expiry");
	disabled_quiet_a: assert property (eval && !enable |=> !start && !alarm && !blocked)
		else $error("disabled channel active");
endmodule

// [tb/hdm_relay_logic.sv]
/*
 Stand-in for the relay's blocking matrix and user logic around the monitor.
 Assumes the bench raises blk_req well ahead of any alarm delay expiry.
*/
`timescale 1ns/100ps
module hdm_relay_logic import hdm_pkg::*; (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Matrix request and blocking line
	input wire logic blk_req,
	output logic blocking_in,
	// Events seen by user logic
	input wire logic [HDM_NSRC-1:0] evt_on,
	input wire logic [HDM_NSRC-1:0] evt_off,
	output logic [HDM_NSRC-1:0] seen_on,
	output logic [HDM_NSRC-1:0] seen_off
);
	always_ff @(posedge aclk) begin
		blocking_in <= aresetn & blk_req;
		seen_on <= aresetn ? (seen_on | evt_on) : 7'h00;
		seen_off <= aresetn ? (seen_off | evt_off) : 7'h00;
	end
endmodule

// [tb/test_harmonic_distortion_alarm_monitor.sv]
/*
 Self-checking bench: register access over AXI4-Lite and channel scenarios.
 Assumes a 10-clock processing cycle so delays of a few steps run quickly.
*/
`timescale 1ns/100ps
module test_harmonic_distortion_alarm_monitor import hdm_pkg::*;;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, blk_req = 0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0] bresp, rresp, monitor_state;
	logic awready, wready, bvalid, arready, rvalid, blocking_in, chan_blocked;
	logic [4:0][15:0] amp = '0, pow = '0;
	logic [47:0] time_ms = 48'h1234, evt_time;
	logic [2:0] grp = 3'h3, chan_start, chan_alarm;
	logic [6:0] evt_on, evt_off, seen_on, seen_off;
	int errors = 0, num_checks = 0, cyc = 0;
	always #2 aclk = ~aclk;
	hdm_top #(.CYCLE_CLKS(10), .LOG_DEPTH(12)) dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .meas_amp(amp), .meas_pow(pow), .blocking_in(blocking_in), .time_ms(time_ms),
		.setting_group(grp), .chan_start(chan_start), .chan_alarm(chan_alarm), .chan_blocked(chan_blocked),
		.monitor_state(monitor_state), .evt_on(evt_on), .evt_off(evt_off), .evt_time(evt_time));
	hdm_relay_logic partner (.aclk(aclk), .aresetn(aresetn), .blk_req(blk_req), .blocking_in(blocking_in),
		.evt_on(evt_on), .evt_off(evt_off), .seen_on(seen_on), .seen_off(seen_off));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Indications packed: alarm nibble [14:12], start nibble [10:8], state [1:0]
	function automatic logic [31:0] ind();
		return {16'h0, 1'b0, chan_alarm, 1'b0, chan_start, 6'h0, monitor_state};
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit ad = 0, wd = 0;
		@(posedge aclk);
		awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (awready && !ad) begin ad = 1; awvalid <= 0; end
			if (wready && !wd) begin wd = 1; wvalid <= 0; end
		end
		do @(posedge aclk); while (!bvalid);
		bready <= 0;
		chk(32'(bresp), 32'(HDM_RESP_OKAY));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = HDM_RESP_OKAY);
		@(posedge aclk);
		araddr <= a; arvalid <= 1; rready <= 1;
		do @(posedge aclk); while (!arready);
		arvalid <= 0;
		do @(posedge aclk); while (!rvalid);
		rready <= 0;
		chk(rdata, exp);
		chk(32'(rresp), 32'(er));
	endtask
	task automatic wt(input int n);
		repeat (n * 10) @(posedge aclk);
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			final_report();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1;
		rd(HDM_OFF_CTRL, 32'h7);
		rd(HDM_OFF_PICKUP0, 32'h3e8);
		rd(HDM_OFF_DELAY0, 32'h7d0);
		rd(8'h1c, 32'h7d0);
		rd(HDM_OFF_EVT_MASK, 32'h7f7f);
		rd(8'h44, 32'h0, HDM_RESP_SLVERR);
		for (int i = 0; i < 3; i++) wr(8'h14 + 8'(4 * i), 32'h3);
		amp[1] <= 16'h03e9;
		wt(2);
		chk(ind(), 32'h0000_0101);
		wt(3);
		chk(ind(), 32'h0000_1102);
		amp[1] <= 16'h03cb;
		wt(3);
		chk(32'(chan_alarm), 32'h1);
		amp[1] <= 16'h03c9;
		wt(3);
		chk(ind(), 32'h0);
		rd(HDM_OFF_CNT0, 32'h1);
		rd(8'h28, 32'h1);
		rd(HDM_OFF_LOG_CTRL, 32'h220);
		rd(HDM_OFF_LOG_W0, 32'h1234);
		rd(8'h38, 32'h00300000);
		rd(8'h3c, 32'h03e90000);
		chk(evt_time[31:0], 32'h1234);
		blk_req <= 1;
		amp[3] <= 16'h07d0;
		wt(3);
		chk({chan_blocked, chan_start, 26'h0, monitor_state}, 32'h80000003);
		blk_req <= 0;
		amp[3] <= 16'h0;
		amp[4] <= 16'h07d0;
		wt(3);
		chk({chan_blocked, chan_start, 28'h0}, 32'h40000000);
		blk_req <= 1;
		wt(2);
		chk({chan_blocked, chan_start, 28'h0}, 32'h80000000);
		blk_req <= 0;
		amp[4] <= 16'h0;
		wt(3);
		rd(HDM_OFF_CNT0, 32'h2);
		rd(8'h2c, 32'h2);
		chk({seen_on, 9'h0, seen_off, 9'h0}, 32'h9a009a00);
		wr(HDM_OFF_CTRL, 32'h17);
		rd(HDM_OFF_CNT0, 32'h0);
		wr(HDM_OFF_CTRL, 32'h6);
		amp[0] <= 16'h0bb8;
		wt(3);
		chk(32'(chan_start), 32'h0);
		wr(HDM_OFF_CTRL, 32'hf);
		wt(3);
		chk(32'(chan_start), 32'h0);
		pow[0] <= 16'h0bb8;
		wt(3);
		chk(32'(chan_start), 32'h1);
		// Residual one alarm ON left out of the event mask
		wr(HDM_OFF_EVT_MASK, 32'h7f6f);
		pow[3] <= 16'h07d0;
		wt(5);
		chk(32'(chan_alarm), 32'h3);
		chk(32'(seen_on), 32'h4f);
		rd(8'h28, 32'h2);
		final_report();
	end
endmodule
